// file: core/exmb_map.svh
// constants of the external memory bus pin block
`ifndef EXMB_MAP_SVH
`define EXMB_MAP_SVH
`define EXMB_ONCHIP_TOP   16'h3FFF
`define EXMB_STRAP_RESET  1'b0
`define EXMB_RANGE_ALL    2'h3
`define EXMB_RANGE_LO64K  2'h2
`define EXMB_RANGE_HI     2'h1
`define EXMB_RANGE_NONE   2'h0
`define EXMB_HALF_MARK    16'h8000
`define EXMB_ALE_CYCLES   1
`define EXMB_DATA_CYCLES  2
`endif

// file: core/exmb_pkg.sv
// types of the external memory bus pin block
`default_nettype none
package exmb_pkg;
  typedef enum logic [4:0] {
    EXMB_IDLE  = 5'h01,
    EXMB_ALE   = 5'h02,
    EXMB_HOLD  = 5'h04,
    EXMB_DATA  = 5'h08,
    EXMB_DONE  = 5'h10
  } exmb_state_type;
endpackage : exmb_pkg
`default_nettype wire

// file: core/exmb_sel_if.sv
// route signals between the bus sequencer and the fetch router
`timescale 1ns/1ps
`default_nettype none
interface exmb_sel_if;
  logic        strap_n_latched;
  logic [15:0] addr;
  logic        is_code;
  logic        go_external;
  modport router (input strap_n_latched, input addr, input is_code,
                  output go_external);
  modport seq (output strap_n_latched, output addr, output is_code,
               input go_external);
endinterface : exmb_sel_if
`default_nettype wire

// file: core/exmb_router.sv
// decides whether an access goes on-chip or off-chip
`timescale 1ns/1ps
`default_nettype none
`include "exmb_map.svh"
module exmb_router (
  exmb_sel_if.router sel
);
  // strap low: all code off-chip; high: off-chip only above on-chip top
  always_comb begin
    if (!sel.is_code)
      sel.go_external = 1'b1;
    else if (!sel.strap_n_latched)
      sel.go_external = 1'b1;
    else
      sel.go_external = (sel.addr > `EXMB_ONCHIP_TOP);
  end
endmodule : exmb_router
`default_nettype wire

// file: core/exmb_bus.sv
// external memory bus pin sequencer
// What this block does
// - ALE marks each external bus cycle with address valid
// - non-page: port zero muxes A7:0/data, port two upper
// - page: port zero low address, port two shared
// - select low sends all fetches off-chip
// - select high: on-chip if in range
// - select captured at reset, later changes ignored
// - code strobe asserted within configured range
// - data read strobe on external data reads
`timescale 1ns/1ps
`default_nettype none
`include "exmb_map.svh"
module exmb_bus (
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        CODE_ACCESS_SELECT_N,
  input  wire logic        PAGE_MODE,
  input  wire logic        STROBE_RANGE_SEL_HI,
  input  wire logic        STROBE_RANGE_SEL_LO,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_CODE,
  input  wire logic        REQ_WRITE,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_WDATA,
  output logic             REQ_READY,
  output logic             RSP_VALID,
  output logic             RSP_EXTERNAL,
  output logic [7:0]       RSP_RDATA,
  output logic             ALE,
  output logic             CODE_READ_STROBE_N,
  output logic             DATA_READ_STROBE_N,
  output logic             DATA_WRITE_STROBE_N,
  input  wire logic [7:0]  PORT_ZERO_IN,
  output logic [7:0]       PORT_ZERO_OUT,
  output logic [7:0]       PORT_ZERO_OE,
  input  wire logic [7:0]  PORT_TWO_IN,
  output logic [7:0]       PORT_TWO_OUT,
  output logic [7:0]       PORT_TWO_OE
);
  // ------------------------------------------------------------
  // routing
  // ------------------------------------------------------------
  exmb_sel_if sel ();
  exmb_router u_router (.sel(sel));

  exmb_pkg::exmb_state_type state_r, state_nxt;
  logic        strap_r, strap_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        code_r, code_nxt;
  logic        write_r, write_nxt;
  logic        ext_r, ext_nxt;
  logic        page_r, page_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic        rext_r, rext_nxt;

  assign sel.strap_n_latched = strap_r;
  assign sel.addr         = REQ_ADDR;
  assign sel.is_code      = REQ_CODE;

  // code strobe window from the two range bits
  function automatic logic in_range(input logic [1:0] rsel,
                                    input logic [15:0] a);
    if (rsel == `EXMB_RANGE_ALL)
      in_range = 1'b1;
    else if (rsel == `EXMB_RANGE_LO64K)
      in_range = (a < `EXMB_HALF_MARK);
    else if (rsel == `EXMB_RANGE_HI)
      in_range = (a >= `EXMB_HALF_MARK);
    else
      in_range = 1'b0;
  endfunction : in_range

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    strap_nxt  = strap_r;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    code_nxt   = code_r;
    write_nxt  = write_r;
    ext_nxt    = ext_r;
    page_nxt   = page_r;
    cnt_nxt    = cnt_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    rext_nxt   = rext_r;
    // strap sampled while reset is held, frozen afterwards
    if (SRST)
      strap_nxt = CODE_ACCESS_SELECT_N;
    case (state_r)
      exmb_pkg::EXMB_IDLE: begin
        if (REQ_VALID) begin
          addr_nxt  = REQ_ADDR;
          wdata_nxt = REQ_WDATA;
          code_nxt  = REQ_CODE;
          write_nxt = REQ_WRITE & ~REQ_CODE;
          ext_nxt   = sel.go_external;
          page_nxt  = PAGE_MODE;
          if (sel.go_external)
            state_nxt = exmb_pkg::EXMB_ALE;
          else
            state_nxt = exmb_pkg::EXMB_DONE;
        end
      end
      exmb_pkg::EXMB_ALE:
        state_nxt = exmb_pkg::EXMB_HOLD;
      exmb_pkg::EXMB_HOLD: begin
        cnt_nxt   = 2'h0;
        state_nxt = exmb_pkg::EXMB_DATA;
      end
      exmb_pkg::EXMB_DATA: begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == 2'(`EXMB_DATA_CYCLES - 1)) begin
          rdata_nxt = page_r ? PORT_TWO_IN : PORT_ZERO_IN;
          state_nxt = exmb_pkg::EXMB_DONE;
        end
      end
      exmb_pkg::EXMB_DONE: begin
        rvalid_nxt = 1'b1;
        rext_nxt   = ext_r;
        if (!ext_r)
          rdata_nxt = 8'h00;
        state_nxt  = exmb_pkg::EXMB_IDLE;
      end
      default:
        state_nxt = exmb_pkg::EXMB_IDLE;
    endcase
    if (SRST)
      state_nxt = exmb_pkg::EXMB_IDLE;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_r  <= exmb_pkg::EXMB_IDLE;
      addr_r   <= 16'h0000;
      wdata_r  <= 8'h00;
      code_r   <= 1'b0;
      write_r  <= 1'b0;
      ext_r    <= 1'b0;
      page_r   <= 1'b0;
      cnt_r    <= 2'h0;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      rext_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      code_r   <= code_nxt;
      write_r  <= write_nxt;
      ext_r    <= ext_nxt;
      page_r   <= page_nxt;
      cnt_r    <= cnt_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      rext_r   <= rext_nxt;
    end
    strap_r <= strap_nxt; // captured by the clock, not by reset
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  logic addr_phase, data_phase, drive_data;
  assign addr_phase = (state_r == exmb_pkg::EXMB_ALE) ||
                      (state_r == exmb_pkg::EXMB_HOLD);
  assign data_phase = (state_r == exmb_pkg::EXMB_DATA);
  assign drive_data = data_phase & write_r;

  assign REQ_READY    = (state_r == exmb_pkg::EXMB_IDLE);
  assign RSP_VALID    = rvalid_r;
  assign RSP_EXTERNAL = rext_r;
  assign RSP_RDATA    = rdata_r;
  // single pulse; address stays one more cycle past its fall
  assign ALE = (state_r == exmb_pkg::EXMB_ALE);

  assign CODE_READ_STROBE_N = ~(data_phase & code_r &
    in_range({STROBE_RANGE_SEL_HI, STROBE_RANGE_SEL_LO}, addr_r));
  assign DATA_READ_STROBE_N  = ~(data_phase & ~code_r & ~write_r);
  assign DATA_WRITE_STROBE_N = ~drive_data;

  // page mode keeps low address on port zero for the whole cycle
  always_comb begin
    if (page_r) begin
      PORT_ZERO_OUT = addr_r[7:0];
      PORT_ZERO_OE  = (addr_phase | data_phase) ? 8'hFF : 8'h00;
      PORT_TWO_OUT  = addr_phase ? addr_r[15:8] : wdata_r;
      PORT_TWO_OE   = (addr_phase | drive_data) ? 8'hFF : 8'h00;
    end else begin
      PORT_ZERO_OUT = addr_phase ? addr_r[7:0] : wdata_r;
      PORT_ZERO_OE  = (addr_phase | drive_data) ? 8'hFF : 8'h00;
      PORT_TWO_OUT  = addr_r[15:8];
      PORT_TWO_OE   = (addr_phase | data_phase) ? 8'hFF : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_ale_cycle;
    ALE ##1 (!ALE && PORT_ZERO_OE != 8'h00);
  endsequence

  chk_ale_one_pulse: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    $rose(ALE) |-> s_ale_cycle)
    else $error("ale not a single pulse with held address");
  chk_ale_addr_valid: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    ALE |-> (PORT_TWO_OE == 8'hFF && PORT_ZERO_OE == 8'hFF &&
             PORT_TWO_OUT == addr_r[15:8] &&
             PORT_ZERO_OUT == addr_r[7:0]))
    else $error("address not valid at ale");
  chk_nonpage_upper: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    (ALE && !page_r) |-> PORT_TWO_OUT == addr_r[15:8])
    else $error("upper address missing on port two");
  chk_page_low_addr: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    (data_phase && page_r) |-> PORT_ZERO_OUT == addr_r[7:0])
    else $error("page mode low address lost");
  chk_strap_low_ext: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY && REQ_CODE && !strap_r) |=> ALE)
    else $error("fetch not sent off-chip");
  chk_strap_high_int: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    (REQ_VALID && REQ_READY && REQ_CODE && strap_r &&
     REQ_ADDR <= `EXMB_ONCHIP_TOP) |=> !ALE ##1 (RSP_VALID && !RSP_EXTERNAL))
    else $error("in-range fetch went off-chip");
  chk_strap_frozen: assert property (
    @(posedge REF_CLK)
    !SRST && !$past(SRST) |-> $stable(strap_r))
    else $error("latched select changed after reset");
  // the strobe spans both data cycles, so ale lies two or three back
  chk_rd_strobe: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    !DATA_READ_STROBE_N |->
      (!code_r && !write_r && ($past(ALE, 2) || $past(ALE, 3))))
    else $error("data read strobe out of place");
  chk_code_strobe: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    !CODE_READ_STROBE_N |-> (code_r && data_phase))
    else $error("code strobe outside a fetch");
endmodule : exmb_bus
`default_nettype wire

// file: testbench/exmb_mem_model.sv
// partner memory with address latch for the bus pin block
`timescale 1ns/1ps
`default_nettype none
// ----
// memory model
// ----
module exmb_mem_model (
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       page,
  input  wire logic [7:0] p0,
  input  wire logic [7:0] p2,
  output logic      [7:0] d0,
  output logic      [7:0] d2
);
  logic [15:0] a_r = 16'h0000;
  logic [7:0]  n_r = 8'h00;
  logic [7:0]  mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
  end
  // released lines toggle every cycle so stale data never passes as a read
  assign d0 = (!rd_n && !page) ? mem[a_r] : n_r;
  assign d2 = (!rd_n && page) ? mem[a_r] : ~n_r;
  always @(posedge clk) begin
    n_r <= n_r + 8'h01;
    if (ale) a_r <= {p2, p0};
    if (!wr_n) mem[a_r] <= page ? p2 : p0;
  end
endmodule : exmb_mem_model
`default_nettype wire

// file: testbench/tb_external_memory_bus_pins.sv
// self-checking bench for the external memory bus pin block
`timescale 1ns/1ps
`default_nettype none
// ----
// bench top
// ----
module tb_external_memory_bus_pins;
  logic        clk = 1'b0, srst = 1'b1, sel_n = 1'b1, page = 1'b0;
  logic        rhi = 1'b0, rlo = 1'b0, rv = 1'b0, rc = 1'b0, rw = 1'b0;
  logic [15:0] ra = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic        rdy, rspv, rspx, ale, cs_n, ds_n, ws_n, strap_lat, c;
  logic [7:0]  rd, p0o, p0e, p2o, p2e, m0, m2, p0i, p2i;
  logic [7:0]  bm [0:65535];
  logic [15:0] pool [6] = '{16'h0000, 16'h3FFF, 16'h4000, 16'h7FFF,
                            16'h8000, 16'hFFFF};
  int          failures = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  assign p0i = (p0e & p0o) | (~p0e & m0);
  assign p2i = (p2e & p2o) | (~p2e & m2);
  exmb_bus exmb_bus_i (.REF_CLK(clk), .SRST(srst),
    .CODE_ACCESS_SELECT_N(sel_n), .PAGE_MODE(page),
    .STROBE_RANGE_SEL_HI(rhi), .STROBE_RANGE_SEL_LO(rlo), .REQ_VALID(rv),
    .REQ_CODE(rc), .REQ_WRITE(rw), .REQ_ADDR(ra), .REQ_WDATA(wd),
    .REQ_READY(rdy), .RSP_VALID(rspv), .RSP_EXTERNAL(rspx),
    .RSP_RDATA(rd), .ALE(ale), .CODE_READ_STROBE_N(cs_n),
    .DATA_READ_STROBE_N(ds_n), .DATA_WRITE_STROBE_N(ws_n),
    .PORT_ZERO_IN(p0i), .PORT_ZERO_OUT(p0o), .PORT_ZERO_OE(p0e),
    .PORT_TWO_IN(p2i), .PORT_TWO_OUT(p2o), .PORT_TWO_OE(p2e));
  exmb_mem_model exmb_mem_model_i (.clk(clk), .ale(ale),
    .rd_n(cs_n & ds_n), .wr_n(ws_n), .page(page), .p0(p0i), .p2(p2i),
    .d0(m0), .d2(m2));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // strap is sampled in reset, then flipped to prove it is ignored
  task rst(input logic strap);
    srst = 1'b1;
    sel_n = strap;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    strap_lat = strap;
    sel_n = ~strap;
  endtask : rst
  task go(input logic cd, input logic w, input logic [15:0] a);
    int n;
    logic cs, ds, ws, x, s;
    logic [15:0] la;
    n = 0; cs = 1'b0; ds = 1'b0; la = 16'h0000;
    ws = 1'b0;
    chk("ready", 16'h0001, {15'h0, rdy});
    rv = 1'b1; rc = cd; rw = w; ra = a; wd = 8'($urandom);
    page = 1'($urandom);
    {rhi, rlo} = 2'($urandom);
    @(negedge clk);
    rv = 1'b0;
    chk("busy", 16'h0000, {15'h0, rdy});
    for (int i = 0; i < 12 && !rspv; i++) begin
      if (ale) begin
        n++;
        la = {p2o, p0o};
      end
      cs |= !cs_n;
      ds |= !ds_n;
      ws |= !ws_n;
      @(negedge clk);
    end
    x = !cd || !strap_lat || a > 16'h3FFF;
    s = {rhi, rlo} == 2'h3 || ({rhi, rlo} == 2'h2 && !a[15])
        || ({rhi, rlo} == 2'h1 && a[15]);
    chk("response", 16'h0001, {15'h0, rspv});
    chk("external", {15'h0, x}, {15'h0, rspx});
    chk("latch pulses", {15'h0, x}, n[15:0]);
    if (x) chk("latched address", a, la);
    chk("code strobe", {15'h0, x && cd && s}, {15'h0, cs});
    chk("data strobe", {15'h0, x && !cd && !w}, {15'h0, ds});
    chk("write strobe", {15'h0, x && !cd && w}, {15'h0, ws});
    if (w && !cd) bm[a] = wd;
    else if (!x || !cd || s)
      chk("read data", {8'h00, x ? bm[a] : 8'h00}, {8'h00, rd});
  endtask : go
  initial begin
    for (int i = 0; i < 65536; i++) bm[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
    void'($urandom(39702));
    @(negedge clk);
    for (int k = 1; k >= 0; k--) begin
      rst(k[0]);
      repeat (80) begin
        c = 1'($urandom);
        go(c, 1'($urandom) & !c, pool[$urandom % 6]);
      end
    end
    test_done;
  end
  initial begin
    #50000;
    failures++;
    test_done;
  end
endmodule : tb_external_memory_bus_pins
`default_nettype wire
